// ---- hw/dbc_defines.svh ----
// Timing constants and decode values for the dual bridge current chopper.
// Assumes a 50 MHz system clock; included by the chopper by bare name.
`ifndef DBC_DEFINES_SVH
`define DBC_DEFINES_SVH
`define DBC_CLK_HZ 50000000
`define DBC_PWM_HZ 50000
`define DBC_PWM_CYC (`DBC_CLK_HZ / `DBC_PWM_HZ)
`define DBC_MIX_PCT 75
`define DBC_MIX_CYC ((`DBC_PWM_CYC * `DBC_MIX_PCT) / 100)
`define DBC_BLANK_NS 3750
`define DBC_BLANK_CYC ((`DBC_BLANK_NS * (`DBC_CLK_HZ / 1000000) + 999) / 1000)
`define DBC_WAKE_US 1000
`define DBC_WAKE_CYC (`DBC_WAKE_US * (`DBC_CLK_HZ / 1000000))
`define DBC_OCP_CYC 100
`define DBC_SENSE_GAIN 5
`define DBC_SCALE_100 8'h64
`define DBC_SCALE_71 8'h47
`define DBC_SCALE_38 8'h26
`define DBC_SCALE_0 8'h00
`endif

// ---- hw/dbc_pkg.sv ----
// Types shared by the dual bridge current chopper.
// No assumptions beyond a SystemVerilog compiler.
package dbc_pkg;
  typedef enum logic [1:0] {
    DBC_RECIRC_SLOW = 2'h0,
    DBC_RECIRC_MIXED = 2'h1,
    DBC_RECIRC_FAST = 2'h2
  } dbc_recirc_type;
  typedef enum logic [3:0] {
    DBC_ST_OFF = 4'h1,
    DBC_ST_DRIVE = 4'h2,
    DBC_ST_FAST = 4'h4,
    DBC_ST_SLOW = 4'h8
  } dbc_state_type;
  // Per-bridge host controls
  typedef struct packed {
    logic bridge_drive_enable;
    logic winding_direction;
    logic current_scale_msb;
    logic current_scale_lsb;
  } dbc_ctrl_type;
  // Per-bridge gate commands: high and low side of each leg
  typedef struct packed {
    logic hs1;
    logic ls1;
    logic hs2;
    logic ls2;
  } dbc_gate_type;
endpackage

// ---- hw/dbc_chopper.sv ----
// Dual bridge current chopper: PWM chopping, recirculation, faults.
// Assumes all inputs synchronous to i_clk_sys; comparator data arrives digitised.
`timescale 1ns/1ns
`include "dbc_defines.svh"
module dbc_chopper #(
  parameter int PWM_CYC = `DBC_PWM_CYC,
  parameter int WAKE_CYC = `DBC_WAKE_CYC,
  parameter int OCP_CYC = `DBC_OCP_CYC,
  parameter int SW = 12
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_logic_reset_n,
  input wire logic i_low_power_request_n,
  input wire logic i_supply_lockout,
  input wire logic i_thermal_shutdown,
  input wire logic [1:0] i_current_limit,
  input wire dbc_pkg::dbc_ctrl_type [1:0] i_ctrl,
  input wire logic i_recirc_drive,
  input wire logic i_recirc_high,
  input wire logic [1:0][SW-1:0] i_winding_sense_voltage,
  input wire logic [1:0][SW-1:0] i_chop_reference_level,
  input wire logic [1:0] i_zero_current,
  output dbc_pkg::dbc_gate_type [1:0] o_gate,
  output logic [1:0] o_bridge_hiz,
  output logic o_fault_flag_n_out,
  output logic o_fault_flag_n_oe,
  output logic o_ready,
  output logic [1:0] o_overcurrent_shutdown
);
  localparam int BLANK_CYC = `DBC_BLANK_CYC;
  localparam int MIX_CYC = (PWM_CYC * `DBC_MIX_PCT) / 100;
  localparam int CW = $clog2(PWM_CYC + 1);
  localparam int WW = $clog2(WAKE_CYC + 1);
  localparam int OW = $clog2(OCP_CYC + 1);

  // Percentage of full scale for a scale code
  function automatic logic [7:0] scale_pct(input logic msb, input logic lsb);
    case ({msb, lsb})
      2'b00: scale_pct = `DBC_SCALE_100;
      2'b01: scale_pct = `DBC_SCALE_71;
      2'b10: scale_pct = `DBC_SCALE_38;
      default: scale_pct = `DBC_SCALE_0;
    endcase
  endfunction

  // Gate pattern for a state; fast recirculation reverses the drive legs
  function automatic dbc_pkg::dbc_gate_type gate_of(input dbc_pkg::dbc_state_type st,
    input logic dir);
    gate_of = '0;
    case (st)
      dbc_pkg::DBC_ST_DRIVE: gate_of = dir ? 4'b1001 : 4'b0110;
      dbc_pkg::DBC_ST_FAST: gate_of = dir ? 4'b0110 : 4'b1001;
      dbc_pkg::DBC_ST_SLOW: gate_of = 4'b0101;
      default: gate_of = '0;
    endcase
  endfunction

  // Sleep and the host reset both hold the logic idle; lockout as well
  logic run;
  assign run = i_logic_reset_n & i_low_power_request_n & ~i_supply_lockout;

  dbc_pkg::dbc_recirc_type recirc;
  always_comb
  begin
    if (!i_recirc_drive)
      recirc = dbc_pkg::DBC_RECIRC_MIXED;
    else if (i_recirc_high)
      recirc = dbc_pkg::DBC_RECIRC_FAST;
    else
      recirc = dbc_pkg::DBC_RECIRC_SLOW;
  end

  logic [CW-1:0] pwm_cnt_ff;
  logic pwm_start;
  assign pwm_start = run && (pwm_cnt_ff == CW'(PWM_CYC - 1));
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      pwm_cnt_ff <= '0;
    else if (!run || pwm_start)
      pwm_cnt_ff <= '0;
    else
      pwm_cnt_ff <= pwm_cnt_ff + CW'(1);
  end

  // Wake delay: drive is held off for about 1 ms after the logic leaves idle
  logic [WW-1:0] wake_cnt_ff;
  logic ready_ff;
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      wake_cnt_ff <= '0;
    else if (!run)
      wake_cnt_ff <= '0;
    else if (wake_cnt_ff != WW'(WAKE_CYC))
      wake_cnt_ff <= wake_cnt_ff + WW'(1);
  end
  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ready_ff <= 1'b0;
    else
      ready_ff <= run && (wake_cnt_ff == WW'(WAKE_CYC));
  end
  assign o_ready = ready_ff;

  logic fault_n_ff;
  logic [1:0] ocp_ff;
  dbc_pkg::dbc_state_type [1:0] st_ff;
  dbc_pkg::dbc_gate_type [1:0] gate_ff;
  logic [1:0] hiz_ff;

  genvar b;
  generate
    for (b = 0; b < 2; b++)
    begin : g_br
      logic [OW-1:0] lim_cnt_ff;
      logic [7:0] blank_cnt_ff;
      // Two spare bits: a full-scale sense word times 500 overflows SW+8 bits
      logic [SW+9:0] sense_x;
      logic [SW+9:0] ref_x;
      logic trip;
      logic allowed;
      dbc_pkg::dbc_state_type nxt_st;
      // Sense times five times 100 against reference times percentage
      assign sense_x = (SW+10)'(i_winding_sense_voltage[b]) * (SW+10)'(`DBC_SENSE_GAIN * 100);
      assign ref_x = (SW+10)'(i_chop_reference_level[b]) *
        (SW+10)'(scale_pct(i_ctrl[b].current_scale_msb, i_ctrl[b].current_scale_lsb));
      assign trip = (sense_x >= ref_x) && (blank_cnt_ff == 8'(BLANK_CYC));
      assign allowed = ready_ff && !ocp_ff[b] && !i_thermal_shutdown && i_ctrl[b].bridge_drive_enable
        && !(i_ctrl[b].current_scale_msb && i_ctrl[b].current_scale_lsb);

      // Overcurrent qualification, on its own path from the limit indication
      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
          lim_cnt_ff <= '0;
        else if (!run || !i_current_limit[b])
          lim_cnt_ff <= '0;
        else if (lim_cnt_ff != OW'(OCP_CYC))
          lim_cnt_ff <= lim_cnt_ff + OW'(1);
      end
      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
          ocp_ff[b] <= 1'b0;
        else if (!i_logic_reset_n || i_supply_lockout)
          ocp_ff[b] <= 1'b0;
        else if (lim_cnt_ff == OW'(OCP_CYC))
          ocp_ff[b] <= 1'b1;
      end

      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
          blank_cnt_ff <= '0;
        else if (st_ff[b] != dbc_pkg::DBC_ST_DRIVE)
          blank_cnt_ff <= '0;
        else if (blank_cnt_ff != 8'(BLANK_CYC))
          blank_cnt_ff <= blank_cnt_ff + 8'h01;
      end

      always_comb
      begin
        nxt_st = st_ff[b];
        if (!allowed)
          nxt_st = dbc_pkg::DBC_ST_OFF;
        else if (pwm_start)
          nxt_st = dbc_pkg::DBC_ST_DRIVE;
        else
          case (st_ff[b])
            dbc_pkg::DBC_ST_DRIVE:
            begin
              if (trip)
                nxt_st = (recirc == dbc_pkg::DBC_RECIRC_SLOW) ? dbc_pkg::DBC_ST_SLOW :
                  (recirc == dbc_pkg::DBC_RECIRC_MIXED && pwm_cnt_ff >= CW'(MIX_CYC)) ?
                  dbc_pkg::DBC_ST_SLOW : dbc_pkg::DBC_ST_FAST;
            end
            dbc_pkg::DBC_ST_FAST:
            begin
              if (i_zero_current[b])
                nxt_st = dbc_pkg::DBC_ST_OFF;
              else if (recirc == dbc_pkg::DBC_RECIRC_MIXED && pwm_cnt_ff >= CW'(MIX_CYC))
                nxt_st = dbc_pkg::DBC_ST_SLOW;
            end
            dbc_pkg::DBC_ST_SLOW: nxt_st = dbc_pkg::DBC_ST_SLOW;
            default: nxt_st = dbc_pkg::DBC_ST_OFF;
          endcase
      end

      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
          st_ff[b] <= dbc_pkg::DBC_ST_OFF;
        else
          st_ff[b] <= nxt_st;
      end

      // Gates registered from the next state so the outputs track the FSM exactly
      always_ff @(posedge i_clk_sys or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          gate_ff[b] <= '0;
          hiz_ff[b] <= 1'b1;
        end
        else
        begin
          gate_ff[b] <= gate_of(nxt_st, i_ctrl[b].winding_direction);
          hiz_ff[b] <= (nxt_st == dbc_pkg::DBC_ST_OFF);
        end
      end

      chk_min_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        $rose(st_ff[b] == dbc_pkg::DBC_ST_DRIVE) && allowed |->
        (st_ff[b] == dbc_pkg::DBC_ST_DRIVE || !allowed || pwm_start)[*8])
        else $error("drive ended before blanking");
      chk_ocp_latch: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ocp_ff[b] && i_logic_reset_n && !i_supply_lockout |=> ocp_ff[b])
        else $error("overcurrent latch dropped");
      chk_ocp_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        ocp_ff[b] |=> ##1 (gate_ff[b] == '0) && hiz_ff[b])
        else $error("bridge driven during overcurrent");
      chk_scale_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        i_ctrl[b].current_scale_msb && i_ctrl[b].current_scale_lsb |=> gate_ff[b] == '0)
        else $error("bridge on with zero scale");
      chk_slow_gate: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        st_ff[b] == dbc_pkg::DBC_ST_SLOW && $stable(st_ff[b]) |-> gate_ff[b] == 4'b0101)
        else $error("slow recirculation gates wrong");
    end
  endgenerate

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
      fault_n_ff <= 1'b1;
    else
      fault_n_ff <= !((|ocp_ff) || (run && i_thermal_shutdown));
  end

  assign o_gate = gate_ff;
  assign o_bridge_hiz = hiz_ff;
  assign o_fault_flag_n_out = 1'b0;
  assign o_fault_flag_n_oe = fault_n_ff;
  assign o_overcurrent_shutdown = ocp_ff;

  chk_ready_wait: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !run ##1 run |-> !ready_ff [*8])
    else $error("ready too soon after idle");
  chk_idle_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !run |=> ##1 (o_bridge_hiz == 2'b11))
    else $error("bridge driven while idle");
  chk_fault_pin: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    $rose(|ocp_ff) |=> !o_fault_flag_n_oe)
    else $error("fault flag not pulled low");
endmodule

// ---- verif/dbc_host_model.sv ----
// Host side model: drives the chopper's parallel control pins.
// Assumes the bench sets wanted levels off the falling edge; pins move on it.
`timescale 1ns/1ns
module dbc_host_model (
  input wire logic i_clk_sys,
  input wire logic i_reset_n_want,
  input wire logic i_sleep_n_want,
  input wire dbc_pkg::dbc_recirc_type i_mode_want,
  input wire dbc_pkg::dbc_ctrl_type [1:0] i_ctrl_want,
  output logic o_logic_reset_n = 1'b1,
  output logic o_low_power_request_n = 1'b1,
  output logic o_recirc_drive = 1'b1,
  output logic o_recirc_high = 1'b0,
  output dbc_pkg::dbc_ctrl_type [1:0] o_ctrl = '0
);
  always @(negedge i_clk_sys)
  begin
    o_logic_reset_n <= i_reset_n_want;
    o_low_power_request_n <= i_sleep_n_want;
    o_ctrl <= i_ctrl_want;
    o_recirc_drive <= i_mode_want != dbc_pkg::DBC_RECIRC_MIXED;
    // An open select pin sits mid-rail, so its level wanders
    o_recirc_high <= (i_mode_want == dbc_pkg::DBC_RECIRC_MIXED) ? !o_recirc_high :
      (i_mode_want == dbc_pkg::DBC_RECIRC_FAST);
  end
endmodule

// ---- verif/testbench.sv ----
// Self-checking bench for the dual bridge current chopper.
// Assumes dbc_pkg, the chopper and the host model are compiled first.
`timescale 1ns/1ns
module testbench;
  localparam int PWM = 400;
  localparam int WAKE = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic rst_want = 1'b1;
  logic slp_want = 1'b1;
  dbc_pkg::dbc_recirc_type mode = dbc_pkg::DBC_RECIRC_SLOW;
  dbc_pkg::dbc_ctrl_type [1:0] cw = '0;
  dbc_pkg::dbc_ctrl_type [1:0] ctrl;
  dbc_pkg::dbc_gate_type [1:0] gate;
  logic lrst_n, slp_n, rdrv, rhigh, flag_out, flag_oe, ready;
  logic lockout = 1'b0;
  logic hot = 1'b0;
  logic [1:0] limit = 2'h0, zero = 2'h0, hiz, overcurrent_shutdown;
  logic [1:0][11:0] sense = '0;
  logic [1:0][11:0] vref = {12'h064, 12'h064};
  int bad_count = 0, check_count = 0, n;

  dbc_host_model dbc_host_model_i (.i_clk_sys(clk), .i_reset_n_want(rst_want),
    .i_sleep_n_want(slp_want), .i_mode_want(mode), .i_ctrl_want(cw),
    .o_logic_reset_n(lrst_n), .o_low_power_request_n(slp_n), .o_recirc_drive(rdrv),
    .o_recirc_high(rhigh), .o_ctrl(ctrl));
  dbc_chopper #(.PWM_CYC(PWM), .WAKE_CYC(WAKE), .OCP_CYC(4)) dbc_chopper_i (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_logic_reset_n(lrst_n),
    .i_low_power_request_n(slp_n), .i_supply_lockout(lockout), .i_thermal_shutdown(hot),
    .i_current_limit(limit), .i_ctrl(ctrl), .i_recirc_drive(rdrv), .i_recirc_high(rhigh),
    .i_winding_sense_voltage(sense), .i_chop_reference_level(vref), .i_zero_current(zero),
    .o_gate(gate), .o_bridge_hiz(hiz), .o_fault_flag_n_out(flag_out),
    .o_fault_flag_n_oe(flag_oe), .o_ready(ready), .o_overcurrent_shutdown(overcurrent_shutdown));

  initial forever #10 clk = ~clk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic want(input logic c, input string m);
    check_count++;
    if (c !== 1'b1)
    begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Bounded poll; a bridge may first wait out the wake delay and a whole period
  task automatic wait_gate(input int b, input logic [3:0] e);
    n = 0;
    while (gate[b] !== e)
    begin
      cyc(1);
      n++;
      if (n > 1000)
      begin
        want(1'b0, "gate wait bound");
        print_verdict();
      end
    end
  endtask

  // Re-enabling forces a fresh drive phase at the next period start
  task automatic restart(input logic [3:0] v0, input logic [3:0] v1);
    cw = '0;
    cyc(3);
    cw = {v1, v0};
    wait_gate(0, {v0[2], !v0[2], !v0[2], v0[2]});
  endtask

  task automatic test_wake();
    cw = {4'hc, 4'hc};
    wait_gate(0, 4'h9);
    slp_want = 1'b0;
    cyc(3);
    want(hiz === 2'h3 && gate === '0 && ready === 1'b0, "sleep not idle");
    slp_want = 1'b1;
    n = 0;
    while (ready !== 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    want(n >= WAKE && n <= WAKE + 4, "wake delay");
    rst_want = 1'b0;
    cw = {4'hc, 4'hc};
    cyc(PWM + 5);
    want(hiz === 2'h3 && gate === '0, "reset not idle");
    rst_want = 1'b1;
    $display("test_wake done");
  endtask

  task automatic test_bridge();
    restart(4'hc, 4'h0);
    want(hiz === 2'h2, "disabled bridge not floating");
    cw[0] = 4'h8;
    cyc(3);
    want(gate[0] === 4'h6, "direction low");
    cw = {4'hb, 4'hb};
    cyc(PWM + 5);
    want(gate === '0, "scale 11 drives");
    $display("test_bridge done");
  endtask

  task automatic test_scale();
    logic [1:0] code [4] = '{2'h1, 2'h2, 2'h0, 2'h0};
    logic [11:0] sv [4] = '{12'h00f, 12'h00f, 12'h014, 12'h013};
    int pct [4] = '{71, 38, 100, 100};
    logic trip;
    for (int i = 0; i < 4; i++)
    begin
      trip = sv[i] * 500 >= 100 * pct[i];
      @(negedge clk);
      sense[0] = sv[i];
      restart({2'h3, code[i]}, 4'h0);
      cyc(184);
      want(gate[0] === 4'h9, "blanking on-time");
      cyc(11);
      want(gate[0] === (trip ? 4'h5 : 4'h9), "scale trip");
      if (trip)
      begin
        wait_gate(0, 4'h9);
        want(n + 195 >= PWM - 3 && n + 195 <= PWM + 3, "chop period");
      end
    end
    $display("test_scale done");
  endtask

  task automatic test_recirc();
    mode = dbc_pkg::DBC_RECIRC_FAST;
    @(negedge clk);
    sense = {12'h014, 12'h014};
    restart(4'hc, 4'h8);
    cyc(195);
    want(gate === {4'h9, 4'h6}, "fast reverse");
    @(negedge clk);
    zero = 2'h3;
    cyc(2);
    want(gate === '0, "fast not off at zero");
    @(negedge clk);
    zero = 2'h0;
    mode = dbc_pkg::DBC_RECIRC_MIXED;
    restart(4'hc, 4'h0);
    cyc(285);
    want(gate[0] === 4'h6, "mixed not fast");
    cyc(20);
    want(gate[0] === 4'h5, "mixed not slow");
    $display("test_recirc done");
  endtask

  task automatic trip_limit(input int k);
    @(negedge clk);
    limit = 2'h1;
    repeat (k) @(negedge clk);
    limit = 2'h0;
    cyc(2);
  endtask

  task automatic test_faults();
    mode = dbc_pkg::DBC_RECIRC_SLOW;
    @(negedge clk);
    sense = '0;
    restart(4'hc, 4'h8);
    trip_limit(3);
    want(overcurrent_shutdown === 2'h0 && flag_oe === 1'b1, "short limit latched");
    trip_limit(8);
    want(overcurrent_shutdown === 2'h1 && flag_oe === 1'b0 && flag_out === 1'b0, "no ocp flag");
    want(gate[0] === 4'h0 && gate[1] === 4'h6, "ocp bridge gates");
    cyc(PWM);
    want(overcurrent_shutdown === 2'h1 && gate[0] === 4'h0, "ocp not held");
    rst_want = 1'b0;
    cyc(3);
    rst_want = 1'b1;
    cyc(3);
    want(overcurrent_shutdown === 2'h0 && flag_oe === 1'b1, "ocp not cleared");
    trip_limit(8);
    @(negedge clk);
    lockout = 1'b1;
    cyc(3);
    want(overcurrent_shutdown === 2'h0 && hiz === 2'h3 && gate === '0, "lockout not idle");
    @(negedge clk);
    lockout = 1'b0;
    restart(4'hc, 4'h0);
    @(negedge clk);
    hot = 1'b1;
    cyc(3);
    want(flag_oe === 1'b0 && gate[0] === 4'h0, "thermal not stopped");
    @(negedge clk);
    hot = 1'b0;
    cyc(3);
    want(flag_oe === 1'b1, "thermal flag stuck");
    wait_gate(0, 4'h9);
    $display("test_faults done");
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    test_wake();
    test_bridge();
    test_scale();
    test_recirc();
    test_faults();
    print_verdict();
  end
endmodule
